// file: cesc_core.sv
// Core event and synchronisation control: sync, idle, mask and force event.
`timescale 1ns/1ps
`default_nettype none
module cesc_core
    import cesc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire cesc_instr_s instr,
    input wire logic emu_enable,
    input wire logic pending_load_spec,
    input wire logic store_buf_empty,
    input wire logic write_buf_empty,
    input wire logic store_spec_req,
    input wire logic sync_ack_pin,
    input wire logic wakeup_pin,
    input wire logic [NUM_EVENTS-1:0] hw_event_in,
    input wire logic [NUM_EVENTS-1:0] latch_clear,
    input wire logic [NUM_EVENTS-1:0] active_level,
    output logic issue_ready,
    output logic store_issue_allow,
    output logic flush_write_buf,
    output logic sync_req,
    output logic idle_out,
    output logic instr_done,
    output cesc_exc_s exc_q,
    output logic [DATA_W-1:0] data_out_q,
    output logic data_out_valid_q,
    output logic [NUM_EVENTS-1:0] interrupt_mask_reg,
    output logic [NUM_EVENTS-1:0] interrupt_latch_reg,
    output logic [NUM_EVENTS-1:0] sequencer_status_reg,
    output logic service_valid,
    output logic [EVENT_W-1:0] service_event
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic ack_s1_q;
    logic ack_s2_q;
    logic wake_s1_q;
    logic wake_s2_q;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= sync_ack_pin;
            ack_s2_q <= ack_s1_q;
            wake_s1_q <= wakeup_pin;
            wake_s2_q <= wake_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sync sequencer.

    typedef enum logic [2:0] {
        ST_RUN,
        ST_CDRAIN,
        ST_SDRAIN,
        ST_WAIT_ACK,
        ST_IDLE
    } cesc_state_e;

    cesc_state_e state_q;
    cesc_state_e state_d;
    logic [NUM_EVENTS-1:0] mask_q;
    logic [NUM_EVENTS-1:0] mask_d;
    logic [NUM_EVENTS-1:0] latch_q;
    logic [NUM_EVENTS-1:0] latch_d;
    logic idle_req_q;
    logic idle_req_d;
    logic done_d;
    logic done_q;
    cesc_exc_s exc_d;
    logic [DATA_W-1:0] dout_d;
    logic dout_v_d;
    logic [EVENT_W:0] wb_in;
    logic [EVENT_W:0] wb_out;
    logic core_drained;
    logic take;
    logic priv_ok;
    logic solo_bad;

    assign core_drained = !pending_load_spec && store_buf_empty;
    assign take = instr.valid && (state_q == ST_RUN);
    assign priv_ok = instr.supervisor;
    // Solo instructions arriving paired are rejected as illegal.
    assign solo_bad = instr.paired && (instr.op != CESC_OP_OTHER) &&
                      (instr.op != CESC_OP_NONE);

    always_comb begin
        state_d = state_q;
        mask_d = mask_q;
        idle_req_d = idle_req_q;
        done_d = 1'b0;
        exc_d = '0;
        dout_d = data_out_q;
        dout_v_d = 1'b0;
        wb_in = '0;
        if (take && solo_bad) begin
            exc_d.illegal_instr = 1'b1;
        end else if (take) begin
            case (instr.op)
                CESC_OP_CORE_SYNC: begin
                    state_d = ST_CDRAIN;
                end
                CESC_OP_SYS_SYNC: begin
                    state_d = ST_SDRAIN;
                end
                CESC_OP_IDLE: begin
                    if (priv_ok) begin
                        idle_req_d = 1'b1;
                        done_d = 1'b1;
                    end else begin
                        exc_d.protect_fault = 1'b1;
                    end
                end
                CESC_OP_FORCE_EMU: begin
                    if (emu_enable) begin
                        exc_d.emulation_entry = 1'b1;
                    end else begin
                        exc_d.illegal_instr = 1'b1;
                    end
                end
                CESC_OP_MASK_CLEAR: begin
                    if (priv_ok) begin
                        dout_d = {{(DATA_W-NUM_EVENTS){1'b0}}, mask_q};
                        dout_v_d = 1'b1;
                        mask_d = '0;
                        done_d = 1'b1;
                    end else begin
                        exc_d.protect_fault = 1'b1;
                    end
                end
                CESC_OP_MASK_RESTORE: begin
                    if (priv_ok) begin
                        mask_d = instr.data_in[NUM_EVENTS-1:0];
                        done_d = 1'b1;
                    end else begin
                        exc_d.protect_fault = 1'b1;
                    end
                end
                CESC_OP_FORCE_EVENT: begin
                    if (priv_ok) begin
                        wb_in = {1'b1, instr.event_number_imm};
                        done_d = 1'b1;
                    end else begin
                        exc_d.protect_fault = 1'b1;
                    end
                end
                default: begin
                    done_d = 1'b0;
                end
            endcase
        end else begin
            case (state_q)
                ST_CDRAIN: begin
                    if (core_drained) begin
                        state_d = ST_RUN;
                        done_d = 1'b1;
                    end
                end
                ST_SDRAIN: begin
                    // A new request waits for the last acknowledge to drop,
                    // so a stale acknowledge can never end this sync.
                    if (core_drained && write_buf_empty && !ack_s2_q) begin
                        state_d = ST_WAIT_ACK;
                    end
                end
                ST_WAIT_ACK: begin
                    if (ack_s2_q) begin
                        if (idle_req_q) begin
                            state_d = ST_IDLE;
                        end else begin
                            state_d = ST_RUN;
                            done_d = 1'b1;
                        end
                    end
                end
                ST_IDLE: begin
                    if (wake_s2_q) begin
                        state_d = ST_RUN;
                        idle_req_d = 1'b0;
                        done_d = 1'b1;
                    end
                end
                default: begin
                    state_d = ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_q <= ST_RUN;
            mask_q <= MASK_RESET;
            idle_req_q <= 1'b0;
            done_q <= 1'b0;
            exc_q <= '0;
            data_out_q <= '0;
            data_out_valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            mask_q <= mask_d;
            idle_req_q <= idle_req_d;
            done_q <= done_d;
            exc_q <= exc_d;
            data_out_q <= dout_d;
            data_out_valid_q <= dout_v_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Force-event path held back to write-back, and the latch.

    cesc_wb_delay #(
        .DEPTH(PIPE_WB_DELAY),
        .WIDTH(EVENT_W + 1)
    ) u_wb_delay (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_data(wb_in),
        .out_data(wb_out)
    );

    logic [NUM_EVENTS-1:0] force_vec;

    always_comb begin
        force_vec = '0;
        if (wb_out[EVENT_W]) begin
            force_vec[wb_out[EVENT_W-1:0]] = 1'b1;
        end
        // A forced event at a reserved number, the emulation and exception slots among them, never latches.
        force_vec = force_vec & ~RESERVED_EVENTS;
        // A new event wins over a clear in the same cycle.
        latch_d = (latch_q & ~latch_clear) | force_vec | hw_event_in;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            latch_q <= LATCH_RESET;
        end else begin
            latch_q <= latch_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event prioritisation: lowest number is highest priority.

    logic [NUM_EVENTS-1:0] enabled;

    always_comb begin
        enabled = latch_q & (mask_q | ALWAYS_ON_EVENTS);
        service_valid = 1'b0;
        service_event = '0;
        if (exc_q.emulation_entry) begin
            service_valid = 1'b1;
            service_event = EV_EMULATION;
        end else begin
            for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
                if (enabled[i] && !active_level[i]) begin
                    service_valid = 1'b1;
                    service_event = i[EVENT_W-1:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign issue_ready = (state_q == ST_RUN);
    // Stores wait only on speculation, never on the store buffer, so they
    // leave in order behind earlier stores while loads are never held.
    assign store_issue_allow = !pending_load_spec &&
                               !store_spec_req;
    assign flush_write_buf = (state_q == ST_SDRAIN);
    assign sync_req = (state_q == ST_WAIT_ACK);
    assign idle_out = (state_q == ST_IDLE);
    assign instr_done = done_q;
    assign interrupt_mask_reg = mask_q;
    assign interrupt_latch_reg = latch_q;

    always_comb begin
        sequencer_status_reg = '0;
        sequencer_status_reg[IDLE_REQ_BIT] = idle_req_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_ack_seen;
        sync_req && ack_s2_q && !idle_req_q;
    endsequence

    chk_ack_finish: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_ack_seen |=> instr_done && issue_ready)
        else $error("sync did not finish after acknowledge");

    chk_idle_entry: assert property (@(posedge sys_clk) disable iff (!nrst)
        sync_req && ack_s2_q && idle_req_q |=> idle_out)
        else $error("idle not entered after acknowledge");

    chk_idle_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        idle_out && !wake_s2_q |=> idle_out && !issue_ready)
        else $error("idle left without wakeup");

    chk_mask_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
        take && !solo_bad && priv_ok && instr.op == CESC_OP_MASK_CLEAR
        |=> mask_q == '0 && data_out_q[NUM_EVENTS-1:0] == $past(mask_q))
        else $error("mask clear wrong");

    chk_prot_fault: assert property (@(posedge sys_clk) disable iff (!nrst)
        take && !solo_bad && !priv_ok && instr.op == CESC_OP_MASK_RESTORE
        |=> exc_q.protect_fault && $stable(mask_q))
        else $error("user restore not faulted");

    chk_emu_entry: assert property (@(posedge sys_clk) disable iff (!nrst)
        take && !solo_bad && emu_enable && instr.op == CESC_OP_FORCE_EMU
        |=> exc_q.emulation_entry && service_event == EV_EMULATION)
        else $error("emulation not taken");

    chk_force_wb: assert property (@(posedge sys_clk) disable iff (!nrst)
        take && !solo_bad && priv_ok && instr.op == CESC_OP_FORCE_EVENT &&
        instr.event_number_imm == EV_TIMER
        |=> ##2 latch_q[EV_TIMER])
        else $error("force event latch late");

    chk_store_spec: assert property (@(posedge sys_clk) disable iff (!nrst)
        pending_load_spec |-> !store_issue_allow)
        else $error("store allowed while speculative");

    chk_wake_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
        idle_out && wake_s2_q |=> !idle_req_q && instr_done)
        else $error("wakeup did not clear idle request");

    chk_fresh_ack: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(sync_req) |-> !$past(ack_s2_q))
        else $error("sync request raised over a stale acknowledge");

endmodule : cesc_core
`default_nettype wire

// file: cesc_core_tb.sv
// Self-checking testbench for the core event and sync control block.
`timescale 1ns/1ps
`default_nettype none
module cesc_core_tb
    import cesc_pkg::*;
;
    localparam int E_DONE = 0, E_ILL = 1, E_PROT = 2, E_EMU = 3, E_DV = 4;
    logic sys_clk = 1'b0, nrst = 1'b0;
    cesc_instr_s instr = '0;
    logic emu_enable = 1'b0, pending_load_spec = 1'b0, store_spec_req = 1'b0;
    logic store_buf_empty = 1'b1, write_buf_empty = 1'b1;
    logic sync_ack_pin, wakeup_pin, issue_ready, store_issue_allow;
    logic [15:0] hw_event_in = 16'h0000, latch_clear = 16'h0000;
    logic [15:0] active_level = 16'h0000, mask, latch, status;
    logic [7:0] ack_delay = 8'h14, wake_delay = 8'h0F;
    logic flush_write_buf, sync_req, idle_out, instr_done, dval, svc_v;
    cesc_exc_s exc_q;
    logic [31:0] data_out_q;
    logic [3:0] svc_e;
    logic [4:0] ev;
    int err_total = 0, checks_done = 0;
    assign ev = {dval, exc_q.emulation_entry, exc_q.protect_fault,
                 exc_q.illegal_instr, instr_done};
    cesc_core u_cesc_core (.sys_clk(sys_clk), .nrst(nrst), .instr(instr),
        .emu_enable(emu_enable), .pending_load_spec(pending_load_spec),
        .store_buf_empty(store_buf_empty), .write_buf_empty(write_buf_empty),
        .store_spec_req(store_spec_req), .sync_ack_pin(sync_ack_pin),
        .wakeup_pin(wakeup_pin), .hw_event_in(hw_event_in),
        .latch_clear(latch_clear), .active_level(active_level),
        .issue_ready(issue_ready), .store_issue_allow(store_issue_allow),
        .flush_write_buf(flush_write_buf), .sync_req(sync_req),
        .idle_out(idle_out), .instr_done(instr_done), .exc_q(exc_q),
        .data_out_q(data_out_q), .data_out_valid_q(dval),
        .interrupt_mask_reg(mask), .interrupt_latch_reg(latch),
        .sequencer_status_reg(status), .service_valid(svc_v),
        .service_event(svc_e));
    cesc_sys_model u_cesc_sys_model (.sys_clk(sys_clk), .nrst(nrst),
        .sync_req(sync_req), .idle_out(idle_out), .ack_delay(ack_delay),
        .wake_delay(wake_delay), .sync_ack_pin(sync_ack_pin),
        .wakeup_pin(wakeup_pin));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    // Waits for one output pulse; a missing pulse ends the run.
    task automatic wait_ev(input int idx, input int bound);
        int i;
        for (i = 0; i < bound && ev[idx] !== 1'b1; i++) @(negedge sys_clk);
        checks_done++;
        if (ev[idx] !== 1'b1) begin
            err_total++;
            $display("FAIL %0t pulse %0d missing", $time, idx);
            stop_test();
        end
    endtask : wait_ev
    task automatic issue(input cesc_op_e op, input logic sup,
                         input logic pr, input logic [3:0] n,
                         input logic [31:0] d);
        // One edge passes first, so two requests never share a time step.
        @(negedge sys_clk);
        for (int i = 0; i < 300 && issue_ready !== 1'b1; i++) begin
            @(negedge sys_clk);
        end
        chk(issue_ready, 1'b1, "issue not ready");
        instr = '{1'b1, op, pr, sup, n, d};
        @(negedge sys_clk);
        instr.valid = 1'b0;
    endtask : issue
    task automatic clr_latch;
        latch_clear = 16'hFFFF;
        @(negedge sys_clk);
        latch_clear = 16'h0000;
        @(negedge sys_clk);
    endtask : clr_latch
    task automatic raise_ev(input logic [3:0] n, input logic [15:0] exp);
        issue(CESC_OP_FORCE_EVENT, 1'b1, 1'b0, n, 32'h0);
        chk(latch[n], 1'b0, "latch set early");
        for (int i = 0; i < 5 && latch !== exp; i++) @(negedge sys_clk);
        repeat (2) @(negedge sys_clk);
        chk(latch, exp, "latch after force event");
    endtask : raise_ev
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_store;
        chk(mask, 16'h001F, "mask reset");
        chk(latch, 16'h0000, "latch reset");
        chk(status, 16'h0000, "status reset");
        for (int i = 0; i < 4; i++) begin
            {pending_load_spec, store_spec_req} = i[1:0];
            #1;
            chk(store_issue_allow, i == 0, "store allow");
        end
        {pending_load_spec, store_spec_req} = 2'b00;
        store_buf_empty = 1'b0;
        #1;
        chk(store_issue_allow, 1'b1, "store held by buffer");
        store_buf_empty = 1'b1;
        $display("test reset_store done");
    endtask : t_reset_store
    task automatic t_refused;
        cesc_op_e u[4] = '{CESC_OP_MASK_CLEAR, CESC_OP_MASK_RESTORE,
                           CESC_OP_FORCE_EVENT, CESC_OP_IDLE};
        cesc_op_e p[5] = '{CESC_OP_SYS_SYNC, CESC_OP_FORCE_EMU,
            CESC_OP_MASK_CLEAR, CESC_OP_MASK_RESTORE, CESC_OP_FORCE_EVENT};
        foreach (u[i]) begin
            issue(u[i], 1'b0, 1'b0, 4'h9, 32'h0);
            wait_ev(E_PROT, 4);
        end
        foreach (p[i]) begin
            issue(p[i], 1'b1, 1'b1, 4'h9, 32'h0);
            wait_ev(E_ILL, 4);
        end
        repeat (4) @(negedge sys_clk);
        chk(mask, 16'h001F, "refused op changed mask");
        chk(latch, 16'h0000, "refused op set latch");
        chk(status, 16'h0000, "user idle set request");
        chk(sync_req, 1'b0, "paired sync ran");
        $display("test refused done");
    endtask : t_refused
    task automatic t_mask;
        issue(CESC_OP_MASK_CLEAR, 1'b1, 1'b0, 4'h0, 32'h0);
        wait_ev(E_DV, 4);
        chk(data_out_q, 32'h0000001F, "saved mask");
        chk(mask, 16'h0000, "mask cleared");
        raise_ev(EV_NMI, 16'h0004);
        chk({svc_v, svc_e}, {1'b1, EV_NMI}, "nmi under mask");
        clr_latch();
        raise_ev(4'h9, 16'h0200);
        chk(svc_v, 1'b0, "general event not masked");
        issue(CESC_OP_MASK_RESTORE, 1'b1, 1'b0, 4'h0, 32'h0000FFFF);
        repeat (2) @(negedge sys_clk);
        chk(mask, 16'hFFFF, "mask restored");
        chk({svc_v, svc_e}, {1'b1, 4'h9}, "event after restore");
        clr_latch();
        hw_event_in = 16'h0400;
        @(negedge sys_clk);
        hw_event_in = 16'h0000;
        repeat (2) @(negedge sys_clk);
        chk(latch, 16'h0400, "hardware event latched");
        clr_latch();
        $display("test mask done");
    endtask : t_mask
    task automatic t_force_event;
        logic [15:0] e;
        for (int n = 0; n < 16; n++) begin
            e = RESERVED_EVENTS[n] ? 16'h0000 : 16'h0001 << n;
            raise_ev(n[3:0], e);
            if (e != 16'h0000) begin
                chk({svc_v, svc_e}, {1'b1, n[3:0]}, "service");
            end
            if (n >= 7) begin
                active_level = 16'hFFFF;
                #1;
                chk(svc_v, 1'b0, "served while blocked");
                active_level = 16'h0000;
            end
            clr_latch();
        end
        $display("test force_event done");
    endtask : t_force_event
    task automatic t_emu;
        logic seen;
        emu_enable = 1'b1;
        raise_ev(EV_NMI, 16'h0004);
        issue(CESC_OP_FORCE_EMU, 1'b0, 1'b0, 4'h0, 32'h0);
        wait_ev(E_EMU, 4);
        seen = 1'b0;
        for (int i = 0; i < 3; i++) begin
            seen |= (svc_v === 1'b1 && svc_e === EV_EMULATION);
            @(negedge sys_clk);
        end
        chk(seen, 1'b1, "emulation outranks nmi");
        emu_enable = 1'b0;
        issue(CESC_OP_FORCE_EMU, 1'b0, 1'b0, 4'h0, 32'h0);
        wait_ev(E_ILL, 4);
        clr_latch();
        $display("test emu done");
    endtask : t_emu
    task automatic t_core_sync;
        store_buf_empty = 1'b0;
        issue(CESC_OP_CORE_SYNC, 1'b0, 1'b0, 4'h0, 32'h0);
        repeat (4) begin
            chk({issue_ready, instr_done}, 2'b00, "core sync early");
            @(negedge sys_clk);
        end
        store_buf_empty = 1'b1;
        wait_ev(E_DONE, 6);
        $display("test core_sync done");
    endtask : t_core_sync
    task automatic t_sys_sync(input logic idle);
        logic ack_seen;
        int i;
        write_buf_empty = 1'b0;
        issue(CESC_OP_SYS_SYNC, 1'b1, 1'b0, 4'h0, 32'h0);
        repeat (4) begin
            chk({flush_write_buf, sync_req}, 2'b10, "drain phase");
            chk(issue_ready, 1'b0, "issue during sync");
            @(negedge sys_clk);
        end
        write_buf_empty = 1'b1;
        ack_seen = 1'b0;
        for (i = 0; i < 200 && instr_done !== 1'b1 && idle_out !== 1'b1;
             i++) begin
            ack_seen |= sync_ack_pin;
            chk(issue_ready, 1'b0, "issue during sync");
            @(negedge sys_clk);
        end
        if (i == 200) begin
            chk(1'b0, 1'b1, "sync never finished");
            stop_test();
        end
        chk(ack_seen, 1'b1, "done before acknowledge");
        chk({idle_out, instr_done}, {idle, !idle}, "after ack");
        if (idle) begin
            for (i = 0; i < 200 && idle_out === 1'b1; i++) begin
                chk({issue_ready, instr_done}, 2'b00, "left stall");
                @(negedge sys_clk);
            end
            wait_ev(E_DONE, 3);
            chk(status, 16'h0000, "idle request kept");
        end
        $display("test sys_sync done");
    endtask : t_sys_sync
    task automatic t_idle;
        issue(CESC_OP_IDLE, 1'b1, 1'b0, 4'h0, 32'h0);
        @(negedge sys_clk);
        chk(status[IDLE_REQ_BIT], 1'b1, "idle request");
        t_sys_sync(1'b1);
        $display("test idle done");
    endtask : t_idle
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge sys_clk);
        nrst = 1'b1;
        @(negedge sys_clk);
        t_reset_store();
        t_refused();
        t_mask();
        t_force_event();
        t_emu();
        t_core_sync();
        t_sys_sync(1'b0);
        ack_delay = 8'h00;
        t_sys_sync(1'b0);
        t_idle();
        stop_test();
    end
endmodule : cesc_core_tb
`default_nettype wire

// file: cesc_pkg.sv
// Package with constants and types for the core event and sync control block.
// Summary of operation
// - Stores never go to memory speculatively.
// - Loads ordered, stores ordered; loads may pass stores.
// - System sync blocks issue until all drained.
// - System sync drains, flushes write buffers, requests sync.
// - Finish system sync only after acknowledge returns.
// - Idle request plus acknowledge enters idle, asserts idle.
// - Stay stalled in idle until wakeup arrives.
// - Special instructions issue alone, never paired.
// - Forced emulation enters emulation when enabled.
// - Forced emulation is illegal when emulation disabled.
// - Emulation exception outranks every other event.
// - Mask clear zeroes mask, returns old value.
// - Mask clear leaves NMI, reset, exceptions deliverable.
// - Mask clear is supervisor only, else protection fault.
// - Mask restore loads mask from data register.
// - Mask restore is supervisor only, else protection fault.
// - Force event immediate is four bits, 0 to 15.
// - Force event only sets the matching latch bit.
// - Forced event served once its priority is recognised.
// - Numbers 0,3,4 reserved; 1 reset, 2 NMI, 5,6, 7 up.
// - Force event is supervisor only, else protection fault.
// - Force event never sets exception bits, acts at write-back.
// - Idle request set only by supervisor idle instruction.
package cesc_pkg;

    localparam int EVENT_W = 4;
    localparam int NUM_EVENTS = 16;
    localparam int DATA_W = 32;
    localparam logic [NUM_EVENTS-1:0] MASK_RESET = 16'h001F;
    localparam logic [NUM_EVENTS-1:0] LATCH_RESET = 16'h0000;
    localparam logic [NUM_EVENTS-1:0] RESERVED_EVENTS = 16'h0019;
    localparam logic [NUM_EVENTS-1:0] ALWAYS_ON_EVENTS = 16'h001F;
    localparam logic [EVENT_W-1:0] EV_EMULATION = 4'h0;
    localparam logic [EVENT_W-1:0] EV_RESET = 4'h1;
    localparam logic [EVENT_W-1:0] EV_NMI = 4'h2;
    localparam logic [EVENT_W-1:0] EV_EXCEPTION = 4'h3;
    localparam logic [EVENT_W-1:0] EV_HW_ERROR = 4'h5;
    localparam logic [EVENT_W-1:0] EV_TIMER = 4'h6;
    localparam logic [EVENT_W-1:0] EV_GENERAL_FIRST = 4'h7;
    localparam int IDLE_REQ_BIT = 0;
    localparam int PIPE_WB_DELAY = 2;

    typedef enum logic [3:0] {
        CESC_OP_NONE,
        CESC_OP_CORE_SYNC,
        CESC_OP_SYS_SYNC,
        CESC_OP_IDLE,
        CESC_OP_FORCE_EMU,
        CESC_OP_MASK_CLEAR,
        CESC_OP_MASK_RESTORE,
        CESC_OP_FORCE_EVENT,
        CESC_OP_OTHER
    } cesc_op_e;

    typedef struct packed {
        logic valid;
        cesc_op_e op;
        logic paired;
        logic supervisor;
        logic [EVENT_W-1:0] event_number_imm;
        logic [DATA_W-1:0] data_in;
    } cesc_instr_s;

    typedef struct packed {
        logic illegal_instr;
        logic protect_fault;
        logic emulation_entry;
    } cesc_exc_s;

endpackage : cesc_pkg

// file: cesc_sys_model.sv
// Behavioural model of the external system answering sync and wakeup.
`timescale 1ns/1ps
`default_nettype none
module cesc_sys_model (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sync_req,
    input wire logic idle_out,
    input wire logic [7:0] ack_delay,
    input wire logic [7:0] wake_delay,
    output logic sync_ack_pin,
    output logic wakeup_pin
);
    logic [7:0] ack_cnt;
    logic [7:0] wake_cnt;
    initial begin
        sync_ack_pin = 1'b0;
        wakeup_pin = 1'b0;
    end
    // The acknowledge answers a request after a delay and is held until
    // the request drops.
    always @(posedge sys_clk) begin
        if (!nrst || !sync_req) begin
            ack_cnt <= 8'h00;
            sync_ack_pin <= 1'b0;
        end else if (ack_cnt >= ack_delay) begin
            sync_ack_pin <= 1'b1;
        end else begin
            ack_cnt <= ack_cnt + 8'h01;
        end
    end
    // Wakeup ends the idle stall and is held until idle is released.
    always @(posedge sys_clk) begin
        if (!nrst || !idle_out) begin
            wake_cnt <= 8'h00;
            wakeup_pin <= 1'b0;
        end else if (wake_cnt >= wake_delay) begin
            wakeup_pin <= 1'b1;
        end else begin
            wake_cnt <= wake_cnt + 8'h01;
        end
    end
endmodule : cesc_sys_model
`default_nettype wire

// file: cesc_wb_delay.sv
// Write-back delay line for force-event requests.
`timescale 1ns/1ps
`default_nettype none
module cesc_wb_delay
    import cesc_pkg::*;
#(
    parameter int DEPTH = PIPE_WB_DELAY,
    parameter int WIDTH = EVENT_W + 1
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] in_data,
    output logic [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] stage_q [DEPTH];
    logic [WIDTH-1:0] stage_d [DEPTH];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_stage
            always_comb begin
                if (g == 0) begin
                    stage_d[g] = in_data;
                end else begin
                    stage_d[g] = stage_q[(g == 0) ? 0 : g - 1];
                end
            end
            always_ff @(posedge sys_clk) begin
                if (!nrst) begin
                    stage_q[g] <= '0;
                end else begin
                    stage_q[g] <= stage_d[g];
                end
            end
        end
    endgenerate

    assign out_data = stage_q[DEPTH-1];

endmodule : cesc_wb_delay
`default_nettype wire
